// >>> inc/hlt_pkg.sv
// Shared constants, register map and types of the hardware-limit period timer.
package hlt_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int HLT_DATA_W  = 32;
    localparam int HLT_ADDR_W  = 8;
    localparam int HLT_CNT_W   = 8;
    localparam int HLT_PS_W    = 4;
    localparam int HLT_MODE_W  = 5;
    localparam int HLT_IRQ_W   = 2;
    localparam int HLT_SYNC_N  = 2;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [HLT_ADDR_W-1:0] HLT_OFS_CTRL     = 8'h00;
    localparam logic [HLT_ADDR_W-1:0] HLT_OFS_MODE     = 8'h04;
    localparam logic [HLT_ADDR_W-1:0] HLT_OFS_PERIOD   = 8'h08;
    localparam logic [HLT_ADDR_W-1:0] HLT_OFS_COUNT    = 8'h0c;
    localparam logic [HLT_ADDR_W-1:0] HLT_OFS_POSTSC   = 8'h10;
    localparam logic [HLT_ADDR_W-1:0] HLT_OFS_IRQ_STAT = 8'h14;
    localparam logic [HLT_ADDR_W-1:0] HLT_OFS_IRQ_MASK = 8'h18;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int HLT_CTRL_ON_BIT  = 0;
    localparam int HLT_IRQ_POST_BIT = 0;
    localparam int HLT_IRQ_DONE_BIT = 1;

    localparam logic [HLT_CNT_W-1:0]  HLT_PERIOD_RST = 8'hff;
    localparam logic [HLT_CNT_W-1:0]  HLT_COUNT_RST  = 8'h00;
    localparam logic [HLT_MODE_W-1:0] HLT_MODE_RST   = 5'h00;
    localparam logic [HLT_PS_W-1:0]   HLT_PS_RST     = 4'h0;
    localparam logic [HLT_IRQ_W-1:0]  HLT_IRQ_RST    = 2'h0;
    localparam logic [HLT_DATA_W-1:0] HLT_RD_ZERO    = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Mode classes (upper two mode bits) and sub-codes (lower three)
    // ------------------------------------------------------------------
    localparam logic [1:0] HLT_CLS_FREE    = 2'h0;
    localparam logic [1:0] HLT_CLS_ONESHOT = 2'h1;
    localparam logic [1:0] HLT_CLS_MONO    = 2'h2;

    localparam logic [2:0] HLT_SUB_SOFT     = 3'h0;
    localparam logic [2:0] HLT_SUB_GATE_HI  = 3'h1;
    localparam logic [2:0] HLT_SUB_GATE_LO  = 3'h2;
    localparam logic [2:0] HLT_SUB_ANY      = 3'h3;
    localparam logic [2:0] HLT_SUB_RISE     = 3'h4;
    localparam logic [2:0] HLT_SUB_FALL     = 3'h5;
    localparam logic [2:0] HLT_SUB_LVL_LO   = 3'h6;
    localparam logic [2:0] HLT_SUB_LVL_HI   = 3'h7;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        HLT_STOP,
        HLT_WAIT,
        HLT_COUNT
    } hlt_run_t;

    typedef struct packed {
        logic [HLT_CNT_W-1:0] count;
        logic                 period_match;
        logic                 postscaled;
        logic                 hw_reset;
    } hlt_pwm_t;

endpackage

// >>> rtl/hlt_sync.sv
// Multi-stage synchroniser for levels entering the timer logic.
`timescale 1ns/100ps
`default_nettype none
module hlt_sync #(
    parameter int WIDTH  = 1,
    parameter int STAGES = 2
) (
    input  wire logic             clk_in,
    input  wire logic             rstn_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (STAGES < 2) begin : g_bad_stages
        $error("hlt_sync needs at least two stages");
    end

    logic [WIDTH-1:0] stage [STAGES];

    // ------------------------------------------------------------------
    // Stage chain
    // ------------------------------------------------------------------
    // The first stage feeds only the second; nothing else looks at it.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            stage[0] <= '0;
        end else begin
            stage[0] <= d_in;
        end
    end

    for (genvar i = 1; i < STAGES; i++) begin : g_stage
        always_ff @(posedge clk_in or negedge rstn_in) begin
            if (!rstn_in) begin
                stage[i] <= '0;
            end else begin
                stage[i] <= stage[i-1];
            end
        end
    end

    assign q_out = stage[STAGES-1];

endmodule
`default_nettype wire

// >>> rtl/hlt_timer.sv
// Eight-bit period timer with hardware limit modes, postscaler and APB slave.
`timescale 1ns/100ps
`default_nettype none
module hlt_timer
    import hlt_pkg::*;
#(
    parameter int CNT_W = HLT_CNT_W,
    parameter int PS_W  = HLT_PS_W
) (
    input  wire logic                  clk_in,
    input  wire logic                  rstn_in,
    input  wire logic [HLT_ADDR_W-1:0] paddr_in,
    input  wire logic                  psel_in,
    input  wire logic                  penable_in,
    input  wire logic                  pwrite_in,
    input  wire logic [HLT_DATA_W-1:0] pwdata_in,
    output logic      [HLT_DATA_W-1:0] prdata_out,
    output logic                       pready_out,
    output logic                       pslverr_out,
    input  wire logic                  ext_reset_signal_in,
    output hlt_pwm_t                   pwm_out,
    output logic                       run_control_out,
    output logic                       irq_out
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (CNT_W != HLT_CNT_W || PS_W != HLT_PS_W) begin : g_bad_width
        $error("hlt_timer widths must match the package types");
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic                  run_control;
    logic [HLT_MODE_W-1:0] mode;
    logic [CNT_W-1:0]      period_value;
    logic [CNT_W-1:0]      count_value;
    logic [PS_W-1:0]       postscale_select;
    logic [PS_W-1:0]       ps_count;
    logic [HLT_IRQ_W-1:0]  irq_stat;
    logic [HLT_IRQ_W-1:0]  irq_mask;
    logic [HLT_DATA_W-1:0] rd_data;
    logic                  ers_q;
    hlt_run_t              state;
    hlt_run_t              next_state;
    hlt_pwm_t              pwm_q;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    function automatic logic addr_hit(input logic [HLT_ADDR_W-1:0] a);
        return a == HLT_OFS_CTRL || a == HLT_OFS_MODE || a == HLT_OFS_PERIOD ||
               a == HLT_OFS_COUNT || a == HLT_OFS_POSTSC ||
               a == HLT_OFS_IRQ_STAT || a == HLT_OFS_IRQ_MASK;
    endfunction

    function automatic logic [HLT_DATA_W-1:0] read_word(input logic [HLT_ADDR_W-1:0] a);
        logic [HLT_DATA_W-1:0] w;
        w = HLT_RD_ZERO;
        if (a == HLT_OFS_CTRL) begin
            w[HLT_CTRL_ON_BIT] = run_control;
        end else if (a == HLT_OFS_MODE) begin
            w[HLT_MODE_W-1:0] = mode;
        end else if (a == HLT_OFS_PERIOD) begin
            w[CNT_W-1:0] = period_value;
        end else if (a == HLT_OFS_COUNT) begin
            w[CNT_W-1:0] = count_value;
        end else if (a == HLT_OFS_POSTSC) begin
            w[PS_W-1:0] = postscale_select;
        end else if (a == HLT_OFS_IRQ_STAT) begin
            w[HLT_IRQ_W-1:0] = irq_stat;
        end else if (a == HLT_OFS_IRQ_MASK) begin
            w[HLT_IRQ_W-1:0] = irq_mask;
        end
        return w;
    endfunction

    // Zero wait states: every access completes in its first access cycle.
    wire acc       = psel_in & penable_in;
    wire setup     = psel_in & ~penable_in;
    wire hit       = addr_hit(paddr_in);
    wire wr        = acc & pwrite_in & hit;
    wire wr_ctrl   = wr && paddr_in == HLT_OFS_CTRL;
    wire wr_mode   = wr && paddr_in == HLT_OFS_MODE;
    wire wr_period = wr && paddr_in == HLT_OFS_PERIOD;
    wire wr_count  = wr && paddr_in == HLT_OFS_COUNT;
    wire wr_postsc = wr && paddr_in == HLT_OFS_POSTSC;
    wire wr_stat   = wr && paddr_in == HLT_OFS_IRQ_STAT;
    wire wr_mask   = wr && paddr_in == HLT_OFS_IRQ_MASK;

    assign pready_out  = 1'b1;
    assign pslverr_out = acc & ~hit;
    assign prdata_out  = rd_data;

    // Read data is captured in the setup cycle so it leaves a flip-flop.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rd_data <= HLT_RD_ZERO;
        end else if (setup & ~pwrite_in) begin
            rd_data <= read_word(paddr_in);
        end
    end

    // ------------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------------
    // Setting the run bit and the external signal take two clocks to act; a
    // clear of the run bit, by hardware or by a write, still acts at once through run_eff.
    logic [1:0] sync_q;
    hlt_sync #(
        .WIDTH  (2),
        .STAGES (HLT_SYNC_N)
    ) u_sync (
        .clk_in  (clk_in),
        .rstn_in (rstn_in),
        .d_in    ({run_control, ext_reset_signal_in}),
        .q_out   (sync_q)
    );

    wire ers     = sync_q[0];
    wire run_eff = sync_q[1] & run_control;
    wire rise    = ers & ~ers_q;
    wire fall    = ~ers & ers_q;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ers_q <= 1'b0;
        end else begin
            ers_q <= ers;
        end
    end

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    wire [1:0] cls = mode[4:3];
    wire [2:0] sub = mode[2:0];

    wire is_free = cls == HLT_CLS_FREE;
    wire is_one  = cls == HLT_CLS_ONESHOT;
    wire is_mono = cls == HLT_CLS_MONO;
    // Monostable class holds edge starts in its low codes and level one-shot in 110/111.
    wire mono_edge = is_mono && (sub == HLT_SUB_GATE_HI || sub == HLT_SUB_GATE_LO ||
                                 sub == HLT_SUB_ANY);
    wire mono_lvl  = is_mono && (sub == HLT_SUB_LVL_LO || sub == HLT_SUB_LVL_HI);
    wire reserved  = ~is_free & ~is_one & ~mono_edge & ~mono_lvl;

    // Start edge by sub-code: odd rise/fall pairs share one table.
    function automatic logic start_edge(input logic [2:0] s, input logic r, input logic f);
        logic e;
        e = 1'b0;
        if (s == HLT_SUB_GATE_HI || s == HLT_SUB_RISE || s == HLT_SUB_LVL_LO) begin
            e = r;
        end else if (s == HLT_SUB_GATE_LO || s == HLT_SUB_FALL || s == HLT_SUB_LVL_HI) begin
            e = f;
        end else if (s == HLT_SUB_ANY) begin
            e = r | f;
        end
        return e;
    endfunction

    wire need_edge = (is_one && sub != HLT_SUB_SOFT) || mono_edge;
    wire go_edge   = start_edge(sub, rise, fall);

    // Edge limit resets (free codes 011..101, one-shot 100/101) and level resets.
    wire edge_rst = (sub == HLT_SUB_ANY && is_free && (rise | fall)) ||
                    ((is_free || is_one) && sub == HLT_SUB_RISE && rise) ||
                    ((is_free || is_one) && sub == HLT_SUB_FALL && fall);
    wire lvl_rst  = (sub == HLT_SUB_LVL_LO && ~ers) ||
                    (sub == HLT_SUB_LVL_HI && ers);
    wire hw_rst   = run_eff && state == HLT_COUNT && ~reserved && (edge_rst || lvl_rst);

    // Hardware gate: 00001 counts while high, 00010 while low.
    wire gate = ~is_free || (sub == HLT_SUB_GATE_HI ? ers :
                             sub == HLT_SUB_GATE_LO ? ~ers : 1'b1);

    wire counting  = state == HLT_COUNT && run_eff && gate && ~hw_rst;
    wire match_ev  = counting && count_value == period_value;
    wire stop_hit  = match_ev && (is_one || is_mono);
    wire clear_on  = match_ev && (is_one || mono_lvl);
    wire ps_wrap   = match_ev && ps_count == postscale_select;

    // ------------------------------------------------------------------
    // Run state machine
    // ------------------------------------------------------------------
    // The level monostable waits in COUNT with the count held at zero
    // while the reset level lasts, so no start edge is wanted there.
    always_comb begin
        next_state = state;
        case (state)
            HLT_STOP: begin
                if (run_eff && ~reserved) begin
                    next_state = need_edge ? HLT_WAIT : HLT_COUNT;
                end
            end
            HLT_WAIT: begin
                if (!run_eff || reserved) begin
                    next_state = HLT_STOP;
                end else if (go_edge) begin
                    next_state = HLT_COUNT;
                end
            end
            HLT_COUNT: begin
                if (!run_eff || reserved) begin
                    next_state = HLT_STOP;
                end else if (stop_hit) begin
                    next_state = clear_on ? HLT_STOP : HLT_WAIT;
                end
            end
            default: begin
                next_state = HLT_STOP;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= HLT_STOP;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // Counter and postscaler
    // ------------------------------------------------------------------
    // A software write wins over counting; an early reset holds the count
    // at zero, and the two-clock sync delay gives the PWM restart gap.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            count_value <= HLT_COUNT_RST;
        end else if (wr_count) begin
            count_value <= pwdata_in[CNT_W-1:0];
        end else if (hw_rst || match_ev) begin
            count_value <= HLT_COUNT_RST;
        end else if (counting) begin
            count_value <= count_value + 1'b1;
        end
    end

    // Writing the control register restarts the postscaler from zero.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ps_count <= HLT_PS_RST;
        end else if (wr_ctrl || ps_wrap) begin
            ps_count <= HLT_PS_RST;
        end else if (match_ev) begin
            ps_count <= ps_count + 1'b1;
        end
    end

    // PWM side outputs are registered one clock after their cause.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pwm_q <= '0;
        end else begin
            pwm_q <= '{count: count_value, period_match: match_ev,
                       postscaled: ps_wrap, hw_reset: hw_rst};
        end
    end

    assign pwm_out         = pwm_q;
    assign run_control_out = run_control;

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    // A write in the same cycle as a hardware clear of the run bit wins,
    // since software intent is the newer of the two.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            run_control <= 1'b0;
        end else if (wr_ctrl) begin
            run_control <= pwdata_in[HLT_CTRL_ON_BIT];
        end else if (clear_on) begin
            run_control <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mode             <= HLT_MODE_RST;
            period_value     <= HLT_PERIOD_RST;
            postscale_select <= HLT_PS_RST;
            irq_mask         <= HLT_IRQ_RST;
        end else begin
            mode             <= wr_mode ? pwdata_in[HLT_MODE_W-1:0] : mode;
            period_value     <= wr_period ? pwdata_in[CNT_W-1:0] : period_value;
            postscale_select <= wr_postsc ? pwdata_in[PS_W-1:0] : postscale_select;
            irq_mask         <= wr_mask ? pwdata_in[HLT_IRQ_W-1:0] : irq_mask;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt
    // ------------------------------------------------------------------
    // Sticky status, write one to clear; a new event in the clearing
    // cycle survives because the set term is ORed in last.
    wire [HLT_IRQ_W-1:0] irq_set = {clear_on, ps_wrap};
    wire [HLT_IRQ_W-1:0] irq_clr = wr_stat ? pwdata_in[HLT_IRQ_W-1:0] : HLT_IRQ_RST;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_stat <= HLT_IRQ_RST;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
        end
    end

    assign irq_out = |(irq_stat & irq_mask);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    wrap_zero_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        match_ev && !wr_count |=> count_value == HLT_COUNT_RST && pwm_q.period_match)
        else $error("count did not return to zero after a period match");

    gate_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        is_free && sub == HLT_SUB_GATE_HI && !ers && !wr_count |=> $stable(count_value))
        else $error("counter advanced while the hardware gate was closed");

    edge_reset_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        is_free && sub == HLT_SUB_RISE && rise && run_eff && state == HLT_COUNT && !wr_count
        |=> count_value == HLT_COUNT_RST)
        else $error("rising edge did not reset the counter");

    oneshot_clear_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        match_ev && is_one && !wr_ctrl |=> !run_control && state == HLT_STOP)
        else $error("one-shot match did not clear the run bit");

    mono_keep_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        match_ev && mono_edge && !wr_ctrl |=> run_control && state == HLT_WAIT)
        else $error("monostable match lost the run bit or kept counting");

    wait_edge_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        state == HLT_WAIT && !go_edge |=> state != HLT_COUNT)
        else $error("edge-start mode began counting without an edge");

    postscale_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        pwm_q.postscaled |-> $past(match_ev) && $past(ps_count) == $past(postscale_select))
        else $error("postscaled pulse without a matching postscaler count");

    irq_gate_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        pwm_q.postscaled && $past(irq_mask[HLT_IRQ_POST_BIT]) && !$past(wr_mask)
        |-> irq_out)
        else $error("enabled period interrupt did not reach the output");

    sync_delay_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ##2 ers == $past(ext_reset_signal_in, 2))
        else $error("external signal did not take two clocks to pass the sync");

endmodule
`default_nettype wire

// >>> bench/hlt_ers_src.sv
// Model of the external reset and trigger source that drives the timer.
`timescale 1ns/100ps
`default_nettype none
module hlt_ers_src (
    input  wire logic clk_in,
    input  wire logic rstn_in,
    input  wire logic want_in,
    output logic      ers_out
);
    int gap;

    // Each level is held seven clocks before it may change, because the timer
    // relies on this spacing and does not police it.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            gap     <= 0;
            ers_out <= 1'b0;
        end else if (want_in != ers_out && gap >= 6) begin
            ers_out <= want_in;
            gap     <= 0;
        end else if (gap < 6) begin
            gap <= gap + 1;
        end
    end
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking testbench of the hardware-limit period timer.
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import hlt_pkg::*;
;
    logic clk_in = 0, rstn_in = 0, psel = 0, penable = 0, pwrite = 0, want = 0, ers;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, a, b;
    logic        pready, pslverr, run, irq, err;
    hlt_pwm_t    pwm;
    int          n_mismatch = 0, checks = 0, n;

    hlt_timer i_hlt_timer (.clk_in(clk_in), .rstn_in(rstn_in), .paddr_in(paddr),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .ext_reset_signal_in(ers), .pwm_out(pwm), .run_control_out(run), .irq_out(irq));
    hlt_ers_src i_hlt_ers_src (.clk_in(clk_in), .rstn_in(rstn_in), .want_in(want),
        .ers_out(ers));

    always #2.5 clk_in = ~clk_in;

    // --------------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------------
    task report_and_stop();
        if (n_mismatch == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer; the request is held until pready is seen high.
    task xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int i;
        @(posedge clk_in);
        psel <= 1; pwrite <= w; paddr <= ad; pwdata <= d; penable <= 0;
        @(posedge clk_in);
        penable <= 1;
        i = 0;
        do begin @(posedge clk_in); i++; end while (pready !== 1'b1 && i < 20);
        a = prdata; err = pslverr; psel <= 0; penable <= 0;
        // Callers look at outputs only once the write taken at this edge has settled.
        if (pready !== 1'b1) begin n_mismatch++; report_and_stop(); end
        else @(negedge clk_in);
    endtask

    // Waits for a pulse, then counts the clocks to the next one.
    task gap(input bit ps);
        int i;
        i = 0; n = 0;
        do begin @(posedge clk_in); i++; end
        while ((ps ? pwm.postscaled : pwm.period_match) !== 1'b1 && i < 200);
        if ((ps ? pwm.postscaled : pwm.period_match) !== 1'b1) n_mismatch++;
        do begin @(posedge clk_in); n++; end
        while ((ps ? pwm.postscaled : pwm.period_match) !== 1'b1 && n < 200);
    endtask

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task s_reset();
        xfer(0, HLT_OFS_PERIOD, 0); chk("period rst", a, 32'h0000_00ff);
        xfer(0, HLT_OFS_MODE, 0); chk("mode rst", a, 32'h0);
        xfer(0, 8'h1c, 0); chk("unmapped err", err, 1);
        chk("unmapped data", a, 32'h0);
    endtask

    task s_soft_gate();
        xfer(1, HLT_OFS_PERIOD, 2); xfer(1, HLT_OFS_POSTSC, 1);
        xfer(1, HLT_OFS_IRQ_MASK, 1); xfer(1, HLT_OFS_CTRL, 1);
        gap(0); chk("match gap", n, 3);
        gap(1); chk("postscale gap", n, 6);
        xfer(1, HLT_OFS_CTRL, 0); chk("irq set", irq, 1);
        xfer(1, HLT_OFS_IRQ_MASK, 0); chk("irq masked", irq, 0);
        xfer(1, HLT_OFS_IRQ_STAT, 3); xfer(1, HLT_OFS_IRQ_MASK, 1);
        chk("irq cleared", irq, 0);
    endtask

    task s_one_shot();
        xfer(1, HLT_OFS_MODE, 5'h08); xfer(1, HLT_OFS_CTRL, 1);
        n = 0;
        while (run !== 1'b0 && n < 40) begin @(posedge clk_in); n++; end
        chk("run cleared", run, 0);
        xfer(0, HLT_OFS_COUNT, 0); chk("stop at zero", a, 32'h0);
        xfer(0, HLT_OFS_IRQ_STAT, 0); chk("done flag", a[1], 1);
    endtask

    // Gate code 00001 counts only while the external signal is high.
    task s_hw_gate();
        xfer(1, HLT_OFS_PERIOD, 8'h40); xfer(1, HLT_OFS_MODE, 5'h01);
        xfer(1, HLT_OFS_CTRL, 1); repeat (10) @(posedge clk_in);
        xfer(0, HLT_OFS_COUNT, 0); b = a; xfer(0, HLT_OFS_COUNT, 0);
        chk("gate held", a, b);
        @(posedge clk_in); want <= 1; repeat (12) @(posedge clk_in);
        xfer(0, HLT_OFS_COUNT, 0); b = a; xfer(0, HLT_OFS_COUNT, 0);
        chk("gate runs", a == b, 0);
    endtask

    task s_mono();
        @(posedge clk_in); want <= 0; repeat (12) @(posedge clk_in);
        // Stop first and clear the count: a running timer ignores a new mode's start rule.
        xfer(1, HLT_OFS_CTRL, 0); xfer(1, HLT_OFS_COUNT, 0);
        xfer(1, HLT_OFS_MODE, 5'h11); xfer(1, HLT_OFS_CTRL, 1);
        repeat (10) @(posedge clk_in);
        xfer(0, HLT_OFS_COUNT, 0); chk("no edge idle", a, 32'h0);
        @(posedge clk_in); want <= 1; gap(0); chk("retrigger idle", n, 200);
        xfer(0, HLT_OFS_COUNT, 0); chk("mono zero", a, 32'h0);
        chk("mono run kept", run, 1);
        chk("pwm count idle", pwm.count, 0);
    endtask

    // Edge limit code 00100: a rising edge clears the count before the period ends.
    task s_edge_limit();
        @(posedge clk_in); want <= 0;
        xfer(1, HLT_OFS_CTRL, 0); xfer(1, HLT_OFS_COUNT, 0);
        xfer(1, HLT_OFS_MODE, 5'h04); xfer(1, HLT_OFS_CTRL, 1);
        repeat (20) @(posedge clk_in);
        want <= 1; n = 0;
        while (pwm.hw_reset !== 1'b1 && n < 20) begin @(posedge clk_in); n++; end
        chk("hw reset pulse", pwm.hw_reset, 1);
        xfer(0, HLT_OFS_COUNT, 0); chk("early reset", a < 8, 1);
    endtask

    initial begin
        repeat (2) @(posedge clk_in);
        rstn_in <= 1;
        s_reset(); s_soft_gate(); s_one_shot(); s_hw_gate(); s_mono(); s_edge_limit();
        report_and_stop();
    end
endmodule
`default_nettype wire
